// [pkg/dea_pkg.sv]
/*
  constants for the data eeprom access block: register map, control bit
  positions, reset values and write timing.
  assumes a 40 mhz apb clock and 32-bit apb data.
*/
// Contract
// - 256 bytes, 8-bit address 00h..FFh
// - byte write erases then programs, self-timed
// - unlock register reads zero, no storage
// - read/write start only settable, hardware clears
// - write enable zero at power-up inhibits writes
// - reset during write sets write error
// - memory select, row erase kept on error
// - aborting reset zeroes data and address
// - write done sets irq flag, software clears
// - bit 7 selects flash or eeprom
// - bit 6 selects configuration space
// - bit 4 row erase, cleared after write
// - read start ignored when memory select one
// - read lands in data next cycle
// - data register holds until read/write
// - 55h then AAh then write start
// - write enable must precede write start
// - hardware never clears write enable; warm reset clears it here
package dea_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_ADDR    = 8'h00;
  localparam logic [7:0] OFS_DATA    = 8'h04;
  localparam logic [7:0] OFS_CTRL    = 8'h08;
  localparam logic [7:0] OFS_UNLOCK  = 8'h0C;
  localparam logic [7:0] OFS_IRQ     = 8'h10;
  // control bit positions
  localparam int BIT_MEMSEL = 7;
  localparam int BIT_CFGSEL = 6;
  localparam int BIT_FREE   = 4;
  localparam int BIT_WRITE_ERROR_FLAG  = 3;
  localparam int BIT_WRITE_ENABLE   = 2;
  localparam int BIT_WR     = 1;
  localparam int BIT_RD     = 0;
  localparam int BIT_IRQ    = 0;
  // unlock key bytes
  localparam logic [7:0] KEY_FIRST   = 8'h55;
  localparam logic [7:0] KEY_SECOND  = 8'hAA;
  // reset values and erased byte
  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int WRITE_TIME_NS = 100000;
  localparam int WRITE_CYCLES  = WRITE_TIME_NS / CLK_PERIOD_NS;
  // unlock sequence states
  typedef enum logic [1:0] {
    UNL_IDLE  = 2'b00,
    UNL_GOT55 = 2'b01,
    UNL_ARMED = 2'b10
  } dea_unl_type;
endpackage

// [rtl/dea_mem.sv]
/*
  byte array of the data eeprom with erase and program strobes.
  assumes strobes are one-cycle pulses on the system clock.
*/
`timescale 1ns/1ps
module dea_mem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  // clock
  input  logic          pclk,
  // write side
  input  logic          erase_en,
  input  logic          prog_en,
  input  logic [AW-1:0] waddr,
  input  logic [DW-1:0] wdata,
  // read side
  input  logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  // nonvolatile content, so no reset on the array
  logic [DW-1:0] mem_q [0:(1<<AW)-1];

  // erase drives every bit high, program stores the byte
  always_ff @(posedge pclk)
  begin
    if (prog_en)
      mem_q[waddr] <= wdata;
    else if (erase_en)
      mem_q[waddr] <= {DW{1'b1}};
  end

  // combinational read, the top registers it
  assign rdata = mem_q[raddr];
endmodule

// [rtl/dea_top.sv]
/*
  data eeprom access control: apb register slave, unlock sequence,
  one-cycle reads and self-timed erase-then-program byte writes.
  assumes master clear and watchdog resets arrive as synchronous
  one-cycle pulses; power-on reset is presetn.
*/
`timescale 1ns/1ps
module dea_top #(
  parameter int WRITE_CYCLES = dea_pkg::WRITE_CYCLES,
  parameter int AW           = 8
) (
  // clock and reset
  input  logic        pclk,
  input  logic        presetn,
  // apb slave
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [7:0]  paddr,
  input  logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  // warm resets that may abort a write
  input  logic        master_clear_reset,
  input  logic        watchdog_reset,
  // status
  output logic        write_complete_irq_flag,
  output logic        write_busy
);
  // byte-wide registers need exactly 8 address bits
  if (AW != 8)
  begin : g_chk
    $error("dea_top: AW must be 8");
  end

  // registers
  logic [AW-1:0] addr_ff, nxt_addr;       // eeprom_address_reg
  logic [7:0]    data_ff, nxt_data;       // eeprom_data_reg
  logic          memsel_ff, nxt_memsel;   // memory_select
  logic          cfgsel_ff, nxt_cfgsel;   // config_space_select
  logic          free_ff, nxt_free;       // row erase enable
  logic          write_error_flag_ff, nxt_write_error_flag;     // write_error_flag
  logic          write_enable_ff, nxt_write_enable;       // write_enable
  logic          wr_ff, nxt_wr;           // write start/busy
  logic          rd_ff, nxt_rd;           // read start
  logic          irq_ff, nxt_irq;         // write_complete_irq_flag
  logic          eewr_ff, nxt_eewr;       // write targets the eeprom
  logic [AW-1:0] waddr_ff, nxt_waddr;     // captured write address
  logic [7:0]    wdata_ff, nxt_wdata;     // captured write data
  dea_pkg::dea_unl_type unl_ff, nxt_unl;  // unlock sequence
  // apb answer registers
  logic [31:0]   prdata_ff, nxt_prdata;
  logic          pready_ff, nxt_pready;
  logic          pslverr_ff, nxt_pslverr;

  // decoded strobes
  logic          wr_acc;      // write taken this edge
  logic          setup;       // setup cycle of any transfer
  logic          soft_rst;    // warm reset pulse
  logic          wr_start;    // write cycle begins
  logic          tmr_busy;
  logic          tmr_done;
  logic [7:0]    mem_rdata;
  logic          erase_en;
  logic [7:0]    ctrl_view;

  // a register is mapped when its offset is one of ours
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == dea_pkg::OFS_ADDR) || (a == dea_pkg::OFS_DATA) ||
                (a == dea_pkg::OFS_CTRL) || (a == dea_pkg::OFS_UNLOCK) ||
                (a == dea_pkg::OFS_IRQ);
  endfunction

  assign setup    = psel && !penable;
  assign wr_acc   = psel && penable && pready_ff && pwrite && is_mapped(paddr);
  assign soft_rst = master_clear_reset || watchdog_reset;

  // start needs the armed key, an earlier write enable and an idle timer
  assign wr_start = wr_acc && (paddr == dea_pkg::OFS_CTRL) && pwdata[dea_pkg::BIT_WR]
                    && (unl_ff == dea_pkg::UNL_ARMED) && write_enable_ff && !wr_ff
                    && !soft_rst;
  // erase the location as the cycle starts, program at its end
  assign erase_en = wr_start && !memsel_ff && !cfgsel_ff;

  // control view; bit 5 is unimplemented and reads zero
  assign ctrl_view = {memsel_ff, cfgsel_ff, 1'b0, free_ff,
                      write_error_flag_ff, write_enable_ff, wr_ff, rd_ff};

  // register file next state
  always_comb
  begin
    nxt_addr   = addr_ff;
    nxt_data   = data_ff;
    nxt_memsel = memsel_ff;
    nxt_cfgsel = cfgsel_ff;
    nxt_free   = free_ff;
    nxt_write_error_flag  = write_error_flag_ff;
    nxt_write_enable   = write_enable_ff;
    nxt_wr     = wr_ff;
    nxt_rd     = 1'b0;                    // read lasts one cycle
    nxt_irq    = irq_ff;
    nxt_eewr   = eewr_ff;
    nxt_waddr  = waddr_ff;
    nxt_wdata  = wdata_ff;
    nxt_unl    = unl_ff;
    // software writes
    if (wr_acc)
    begin
      case (paddr)
        dea_pkg::OFS_ADDR:
          nxt_addr = pwdata[AW-1:0];
        dea_pkg::OFS_DATA:
          nxt_data = pwdata[7:0];
        dea_pkg::OFS_CTRL:
        begin
          nxt_memsel = pwdata[dea_pkg::BIT_MEMSEL];
          nxt_cfgsel = pwdata[dea_pkg::BIT_CFGSEL];
          nxt_free   = pwdata[dea_pkg::BIT_FREE];
          nxt_write_error_flag  = pwdata[dea_pkg::BIT_WRITE_ERROR_FLAG];
          nxt_write_enable   = pwdata[dea_pkg::BIT_WRITE_ENABLE];
          // read start only sets, and only while memory select is zero
          if (pwdata[dea_pkg::BIT_RD] && !memsel_ff)
            nxt_rd = 1'b1;
        end
        dea_pkg::OFS_IRQ:
          if (pwdata[dea_pkg::BIT_IRQ])
            nxt_irq = 1'b0;               // write one clears
        default:
          nxt_unl = unl_ff;
      endcase
      // unlock tracking: any other write to a mapped register breaks the sequence
      if (paddr == dea_pkg::OFS_UNLOCK && pwdata[7:0] == dea_pkg::KEY_FIRST)
        nxt_unl = dea_pkg::UNL_GOT55;
      else if (paddr == dea_pkg::OFS_UNLOCK && pwdata[7:0] == dea_pkg::KEY_SECOND
               && unl_ff == dea_pkg::UNL_GOT55)
        nxt_unl = dea_pkg::UNL_ARMED;
      else
        nxt_unl = dea_pkg::UNL_IDLE;
    end
    // write cycle start: capture target so later edits cannot disturb it
    if (wr_start)
    begin
      nxt_wr    = 1'b1;
      nxt_eewr  = !memsel_ff && !cfgsel_ff;
      nxt_waddr = addr_ff;
      nxt_wdata = data_ff;
    end
    // read result lands one cycle after the start bit
    if (rd_ff)
      nxt_data = mem_rdata;
    // completion: set wins over a same-cycle software clear
    if (tmr_done)
    begin
      nxt_wr    = 1'b0;
      nxt_irq   = 1'b1;
      nxt_write_error_flag = 1'b0;
      nxt_free  = 1'b0;
    end
    // write enable is cleared here as well, and an in-flight write is aborted
    // warm reset: keeps select bits, zeroes data path
    if (soft_rst)
    begin
      nxt_addr = AW'(dea_pkg::RST_BYTE);
      nxt_data = dea_pkg::RST_BYTE;
      nxt_write_enable = 1'b0;
      nxt_rd   = 1'b0;
      nxt_wr   = 1'b0;
      nxt_unl  = dea_pkg::UNL_IDLE;
      if (wr_ff)
      begin
        nxt_write_error_flag  = 1'b1;
        nxt_memsel = memsel_ff;
        nxt_free   = free_ff;
      end
      else
        nxt_free = 1'b0;
    end
  end

  // register file flops; power-on clears write enable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      addr_ff   <= '0;
      data_ff   <= 8'h00;
      memsel_ff <= 1'b0;
      cfgsel_ff <= 1'b0;
      free_ff   <= 1'b0;
      write_error_flag_ff  <= 1'b0;
      write_enable_ff   <= 1'b0;
      wr_ff     <= 1'b0;
      rd_ff     <= 1'b0;
      irq_ff    <= 1'b0;
      eewr_ff   <= 1'b0;
      waddr_ff  <= '0;
      wdata_ff  <= 8'h00;
      unl_ff    <= dea_pkg::UNL_IDLE;
    end
    else
    begin
      addr_ff   <= nxt_addr;
      data_ff   <= nxt_data;
      memsel_ff <= nxt_memsel;
      cfgsel_ff <= nxt_cfgsel;
      free_ff   <= nxt_free;
      write_error_flag_ff  <= nxt_write_error_flag;
      write_enable_ff   <= nxt_write_enable;
      wr_ff     <= nxt_wr;
      rd_ff     <= nxt_rd;
      irq_ff    <= nxt_irq;
      eewr_ff   <= nxt_eewr;
      waddr_ff  <= nxt_waddr;
      wdata_ff  <= nxt_wdata;
      unl_ff    <= nxt_unl;
    end
  end

  // apb answer: data is sampled in setup, so every access takes one cycle
  always_comb
  begin
    nxt_pready  = setup;
    nxt_pslverr = setup && !is_mapped(paddr);
    nxt_prdata  = 32'h0000_0000;
    if (setup && !pwrite)
    begin
      case (paddr)
        dea_pkg::OFS_ADDR:   nxt_prdata = {24'h00_0000, addr_ff};
        dea_pkg::OFS_DATA:   nxt_prdata = {24'h00_0000, data_ff};
        dea_pkg::OFS_CTRL:   nxt_prdata = {24'h00_0000, ctrl_view};
        dea_pkg::OFS_IRQ:    nxt_prdata = {31'h0000_0000, irq_ff};
        default:             nxt_prdata = 32'h0000_0000; // unlock reads zero
      endcase
    end
  end

  // apb answer flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      prdata_ff  <= nxt_prdata;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  assign prdata                  = prdata_ff;
  assign pready                  = pready_ff;
  assign pslverr                 = pslverr_ff;
  assign write_complete_irq_flag = irq_ff;
  assign write_busy              = wr_ff;

  // self-timed write duration
  dea_wtimer #(
    .CYCLES (WRITE_CYCLES)
  ) u_tmr (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (wr_start),
    .abort   (soft_rst),
    .busy    (tmr_busy),
    .done    (tmr_done)
  );

  // the array; flash and config writes only run the timer
  dea_mem #(
    .AW (AW),
    .DW (8)
  ) u_mem (
    .pclk     (pclk),
    .erase_en (erase_en),
    .prog_en  (tmr_done && eewr_ff),
    .waddr    (wr_start ? addr_ff : waddr_ff),
    .wdata    (wdata_ff),
    .raddr    (addr_ff),
    .rdata    (mem_rdata)
  );

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_rd_one_cycle:   assert property (rd_ff |=> !rd_ff)
    else $error("read start stayed high");
  a_rd_loads_data:  assert property (rd_ff && !soft_rst |=> data_ff == $past(mem_rdata))
    else $error("read data not loaded");
  a_rd_memsel:      assert property ($rose(rd_ff) |-> !$past(memsel_ff))
    else $error("read started with memory select set");
  a_unlock_zero:    assert property (setup && !pwrite && paddr == dea_pkg::OFS_UNLOCK
                                     |=> prdata_ff == 32'h0000_0000)
    else $error("unlock read not zero");
  a_bit5_zero:      assert property (setup && !pwrite && paddr == dea_pkg::OFS_CTRL
                                     |=> prdata_ff[5] == 1'b0)
    else $error("control bit 5 not zero");
  a_wr_needs_key:   assert property ($rose(wr_ff) |-> $past(unl_ff) == dea_pkg::UNL_ARMED
                                     && $past(write_enable_ff))
    else $error("write started without key or enable");
  a_done_sets_irq:  assert property (tmr_done && !soft_rst |=> irq_ff && !wr_ff && !write_error_flag_ff)
    else $error("completion did not set flag");
  a_abort_error:    assert property (soft_rst && wr_ff |=> write_error_flag_ff && addr_ff == '0
                                     && data_ff == 8'h00 && memsel_ff == $past(memsel_ff))
    else $error("aborted write not flagged");
  a_write_enable_kept:      assert property (!soft_rst && !wr_acc |=> write_enable_ff == $past(write_enable_ff))
    else $error("write enable changed by hardware");
  a_wr_busy_timer:  assert property ($rose(wr_ff) |-> tmr_busy [*2])
    else $error("write bit without running timer");

  c_read:   cover property (rd_ff ##1 !rd_ff);
  c_write:  cover property ($rose(wr_ff) ##[1:1000] tmr_done);
  c_abort:  cover property (wr_ff && soft_rst);
endmodule

// [rtl/dea_wtimer.sv]
/*
  self-timed write counter: runs a fixed count after start, pulses done.
  assumes start and abort are one-cycle pulses; abort wins over done.
*/
`timescale 1ns/1ps
module dea_wtimer #(
  parameter int CYCLES = dea_pkg::WRITE_CYCLES
) (
  // clock and reset
  input  logic pclk,
  input  logic presetn,
  // control
  input  logic start,
  input  logic abort,
  // status
  output logic busy,
  output logic done
);
  localparam int CW = $clog2(CYCLES + 1);

  // a count below two leaves no room between erase and program
  if (CYCLES < 2)
  begin : g_chk
    $error("dea_wtimer: CYCLES must be at least 2");
  end

  logic [CW-1:0] cnt_ff;     // cycles left
  logic [CW-1:0] nxt_cnt;
  logic          busy_ff;    // write under way
  logic          nxt_busy;
  logic          done_ff;    // completion pulse
  logic          nxt_done;

  // count down while busy; a new start while busy is ignored
  always_comb
  begin
    nxt_cnt  = cnt_ff;
    nxt_busy = busy_ff;
    nxt_done = 1'b0;
    if (abort)
    begin
      nxt_busy = 1'b0;
      nxt_cnt  = '0;
    end
    else if (busy_ff)
    begin
      if (cnt_ff == CW'(1))
      begin
        nxt_busy = 1'b0;
        nxt_done = 1'b1;
      end
      nxt_cnt = cnt_ff - CW'(1);
    end
    else if (start)
    begin
      nxt_busy = 1'b1;
      nxt_cnt  = CW'(CYCLES);
    end
  end

  // state registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_ff  <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else
    begin
      cnt_ff  <= nxt_cnt;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
    end
  end

  assign busy = busy_ff;
  assign done = done_ff;
endmodule

// [verif/dea_core_model.sv]
/*
  apb master standing in for the processor core that reaches the data
  eeprom special-function registers.
  assumes a slave that raises pready in the access phase; no wait bound here.
*/
`timescale 1ns/1ps
module dea_core_model (
  // clock
  input  wire logic        pclk,
  // apb request
  output logic        psel,
  output logic        penable,
  output logic        pwrite,
  output logic [7:0]  paddr,
  output logic [31:0] pwdata,
  // apb answer
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // bus idle from time zero
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h00000000;
  end

  // one transfer, held until pready is seen high at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed: only the bench watchdog ends a stuck wait
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    // released lines flip so a stale value can never look valid
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask

  // key bytes then write start; caller has already set write enable
  task automatic start_write(input logic [7:0] c, input logic [7:0] k1, input logic [7:0] k2);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, dea_pkg::OFS_UNLOCK, {24'h000000, k1}, r, e);
    xfer(1'b1, dea_pkg::OFS_UNLOCK, {24'h000000, k2}, r, e);
    xfer(1'b1, dea_pkg::OFS_CTRL, {24'h000000, c | 8'h02}, r, e);
  endtask

  // read start with bits 7:6 cleared in the same write
  task automatic read_start();
    logic [31:0] r;
    logic        e;
    xfer(1'b1, dea_pkg::OFS_CTRL, 32'h00000001, r, e);
  endtask
endmodule

// [verif/dea_top_tb.sv]
/*
  self-checking bench for the data eeprom access block with a small
  write time; a queue-free associative model tracks the array.
  assumes the core model as apb master and one 40 mhz clock.
*/
`timescale 1ns/1ps
module dea_top_tb;
  localparam int WCYC = 4;
  localparam logic [7:0] RA = dea_pkg::OFS_ADDR;
  localparam logic [7:0] RD = dea_pkg::OFS_DATA;
  localparam logic [7:0] RC = dea_pkg::OFS_CTRL;
  localparam logic [7:0] RI = dea_pkg::OFS_IRQ;
  // design pins
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        master_clear_reset;
  logic        watchdog_reset;
  logic        write_complete_irq_flag;
  logic        write_busy;
  // bench state
  int          n_errors;
  int          total_checks;
  int          exp_mem [int];
  logic [31:0] rv;
  logic        ev;
  logic [7:0]  a;
  logic [7:0]  d;
  int          n;

  // 25 ns clock
  always #12.5 pclk = ~pclk;

  dea_top #(.WRITE_CYCLES(WCYC), .AW(8)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .master_clear_reset(master_clear_reset), .watchdog_reset(watchdog_reset),
    .write_complete_irq_flag(write_complete_irq_flag), .write_busy(write_busy));

  dea_core_model core (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // single comparison point
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rd(logic [7:0] ad, logic [31:0] exp, string what);
    core.xfer(1'b0, ad, 32'h00000000, rv, ev);
    check(what, rv, exp);
  endtask

  task automatic wr(logic [7:0] ad, logic [31:0] v);
    core.xfer(1'b1, ad, v, rv, ev);
  endtask

  // load address, data, enable writes, then key sequence
  task automatic arm(logic [7:0] ad, logic [7:0] dv, logic [7:0] sel, logic [7:0] k1, logic [7:0] k2);
    wr(RA, {24'h000000, ad});
    wr(RD, {24'h000000, dv});
    wr(RC, {24'h000000, sel | 8'h04});
    core.start_write(sel | 8'h04, k1, k2);
    @(posedge pclk);
    #1;
  endtask

  // count busy cycles, bounded so a stuck write cannot hang
  task automatic wait_idle();
    n = 0;
    while (write_busy === 1'b1 && n < 100)
    begin
      @(posedge pclk);
      #1;
      n++;
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // watchdog: far beyond the expected few hundred cycles
  initial
  begin
    #(25 * 40000);
    n_errors++;
    report_and_stop();
  end

  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    master_clear_reset = 1'b0;
    watchdog_reset = 1'b0;
    n_errors = 0;
    total_checks = 0;
    void'($urandom(32'h200C54A9));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // power-up values
    rd(RC, 32'h00000000, "ctrl reset");
    rd(RA, 32'h00000000, "addr reset");
    rd(RI, 32'h00000000, "irq reset");
    core.xfer(1'b0, 8'h14, 32'h00000000, rv, ev);
    check("unmapped err", {31'h0, ev}, 32'h00000001);
    wr(dea_pkg::OFS_UNLOCK, 32'h00000055);
    rd(dea_pkg::OFS_UNLOCK, 32'h00000000, "unlock read");
    wr(RC, 32'h00000030);
    rd(RC, 32'h00000010, "bit5 zero");
    // write start together with enable must not start
    wr(RC, 32'h00000000);
    core.start_write(8'h04, dea_pkg::KEY_FIRST, dea_pkg::KEY_SECOND);
    @(posedge pclk);
    #1;
    check("busy same write", {31'h0, write_busy}, 32'h00000000);
    // good writes at both ends of the range and at random places
    // last pass targets configuration space: timer runs, array untouched
    for (int i = 0; i < 5; i++)
    begin
      a = (i == 0 || i == 4) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom_range(1, 254));
      d = 8'($urandom);
      arm(a, d, (i == 2) ? 8'h10 : (i == 4) ? 8'h40 : 8'h00, dea_pkg::KEY_FIRST, dea_pkg::KEY_SECOND);
      check("busy start", {31'h0, write_busy}, 32'h00000001);
      if (i == 3)
      begin
        wr(RC, 32'h00000000);
        // look after the edge that took the clearing write
        #1;
        check("wr not cleared", {31'h0, write_busy}, 32'h00000001);
      end
      wait_idle();
      if (i != 3)
        check("write cycles", n, WCYC);
      if (i != 4)
        exp_mem[a] = d;
      repeat (3) @(posedge pclk);
      check("irq set", {31'h0, write_complete_irq_flag}, 32'h00000001);
      rd(RC, (i == 3) ? 32'h00000000 : (i == 4) ? 32'h00000044 : 32'h00000004,
         "ctrl after write");
      wr(RI, 32'h00000001);
      rd(RI, 32'h00000000, "irq cleared");
    end
    // read back every byte written
    foreach (exp_mem[k])
    begin
      wr(RA, k);
      core.read_start();
      rd(RD, exp_mem[k], "read byte");
      rd(RC, 32'h00000000, "rd cleared");
      rd(RD, exp_mem[k], "data held");
    end
    wr(RD, 32'h0000005A);
    rd(RD, 32'h0000005A, "data written");
    // read start refused while memory select is one
    wr(RC, 32'h00000080);
    wr(RC, 32'h00000081);
    rd(RD, 32'h0000005A, "rd ignored");
    rd(RC, 32'h00000080, "rd bit low");
    wr(RC, 32'h00000040);
    rd(RC, 32'h00000040, "cfg select");
    // wrong key order, then wrong second key
    for (int j = 0; j < 2; j++)
    begin
      arm(8'h00, 8'h3C, 8'h00, j ? dea_pkg::KEY_FIRST : dea_pkg::KEY_SECOND, j ? 8'h56 : dea_pkg::KEY_FIRST);
      check("bad key", {31'h0, write_busy}, 32'h00000000);
    end
    // warm reset in mid write: flash path then eeprom path
    for (int j = 0; j < 2; j++)
    begin
      a = 8'h00;
      arm(a, 8'hC3, j ? 8'h00 : 8'h90, dea_pkg::KEY_FIRST, dea_pkg::KEY_SECOND);
      check("busy abort", {31'h0, write_busy}, 32'h00000001);
      @(posedge pclk);
      master_clear_reset <= (j == 0);
      watchdog_reset <= (j == 1);
      @(posedge pclk);
      master_clear_reset <= 1'b0;
      watchdog_reset <= 1'b0;
      rd(RC, j ? 32'h00000008 : 32'h00000098, "write_error_flag kept sel");
      rd(RA, 32'h00000000, "addr zero");
      rd(RD, 32'h00000000, "data zero");
      if (j == 1)
        exp_mem[a] = dea_pkg::ERASED_BYTE;
      wr(RC, 32'h00000000);
      core.read_start();
      rd(RD, exp_mem[a], "abort byte");
    end
    // second power-on reset, with non-zero state to clear
    wr(RC, 32'h000000D4);
    wr(RA, 32'h000000A5);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    rd(RC, 32'h00000000, "ctrl re-reset");
    rd(RA, 32'h00000000, "addr re-reset");
    report_and_stop();
  end
endmodule
